// ---- hw/pelr_params.svh ----
// constants of the event-latch register block
`ifndef PELR_PARAMS_SVH
`define PELR_PARAMS_SVH

// serial link slave address, arbitrary value
`define PELR_I2C_ADDR 7'h48

// register pointers
`define PELR_ADR_VOLT  8'h08
`define PELR_ADR_MASK1 8'h0E
`define PELR_ADR_MASK2 8'h0F
`define PELR_ADR_EV1   8'h11
`define PELR_ADR_EV2   8'h12

// reset values
`define PELR_MASK_RST  8'hFF
`define PELR_EV_RST    8'h00
// 1.85 V in 25 mV steps from 0 V
`define PELR_VOLT_RST  8'h4A

// largest upward step, percent of present value
`define PELR_STEP_PCT  16'd8
`define PELR_PCT_BASE  16'd100

`endif

// ---- hw/pelr_pkg.sv ----
// types of the event-latch register block
package pelr_pkg;

	typedef enum logic [7:0] {
		PELR_IDLE = 8'h01,
		PELR_ADDR = 8'h02,
		PELR_ACKA = 8'h04,
		PELR_WREG = 8'h08,
		PELR_ACKW = 8'h10,
		PELR_WDAT = 8'h20,
		PELR_RDAT = 8'h40,
		PELR_MACK = 8'h80
	} pelr_state_e;

	typedef struct packed {
		pelr_state_e st;
		logic [3:0]  bitCnt;
		logic [7:0]  shift;
		logic        rw;
		logic        nack;
		logic [7:0]  ptr;
		logic        sclPrev;
		logic        sdaPrev;
		logic        sdaOeN;
		logic        sdaOut;
		logic [7:0]  chgPrev;
		logic [3:0]  gpioPrev;
		logic        buckUvPrev;
		logic        ldoUvPrev;
		logic        pbPrev;
		logic [7:0]  mask1;
		logic [7:0]  mask2;
		logic [7:0]  ev1;
		logic [7:0]  ev2;
		logic [7:0]  buckVolt;
		logic        resetReq;
		logic        irq;
	} pelr_state_s;

endpackage

// ---- hw/pmic_event_latch_regs.sv ----
// event latches, masks and buck voltage register behind a serial link
// Overview of operation
// - eight charger state flags are set by rising edges of their state lines.
// - a charger state flag reads 1 after its event and clears when the register is read.
// - a charger state flag raises the interrupt only while its mask bit is clear.
// - the four upper pin flags are set on either edge of pins 3 down to 0.
// - a pin flag clears on read and interrupts only while its mask bit is clear.
// - bits 3 and 2 are set by rising undervoltage of the buck and the linear regulator.
// - a power-good flag reads 1 after undervoltage and clears when read.
// - the pushbutton flag is set on either edge, clears on read, and is maskable.
// - an upward step that is too large trips undervoltage and requests a reset.
// - a lower buck setting is taken in one write with no step limit.
// - the buck setting defaults to 1.85 V and is changed by writing its register.
// - mask bits of 1 suppress, 0 allow, and all default to 1.
`include "pelr_params.svh"

module pmic_event_latch_regs
	import pelr_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       undervoltageLockout,
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOeN,
	input  wire logic [7:0] chargerState,
	input  wire logic [3:0] generalPin,
	input  wire logic       buckUndervoltage,
	input  wire logic       linearUndervoltage,
	input  wire logic       pushbuttonStatus,
	output logic [7:0]      buckVoltage,
	output logic            resetRequest,
	output logic            interrupt
);

	// ****************************************
	// state and reset value
	// ****************************************
	localparam pelr_state_s RST_S = '{
		st: PELR_IDLE, bitCnt: 4'h0, shift: 8'h00, rw: 1'b0,
		nack: 1'b1, ptr: 8'h00, sclPrev: 1'b1, sdaPrev: 1'b1,
		sdaOeN: 1'b1, sdaOut: 1'b0, chgPrev: 8'h00,
		gpioPrev: 4'h0, buckUvPrev: 1'b0, ldoUvPrev: 1'b0,
		pbPrev: 1'b0, mask1: `PELR_MASK_RST,
		mask2: `PELR_MASK_RST, ev1: `PELR_EV_RST,
		ev2: `PELR_EV_RST, buckVolt: `PELR_VOLT_RST,
		resetReq: 1'b0, irq: 1'b0};

	pelr_state_s s_r;
	pelr_state_s s_nxt;

	logic [7:0] chgRise;
	logic [3:0] gpioChg;
	logic       buckRise;
	logic       ldoRise;
	logic       pbChg;
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;
	logic [7:0] rdData;
	logic       doLoad;
	logic       wrEn;
	logic       trip;
	logic [7:0] clr1;
	logic [7:0] clr2;
	logic       pending;

	// ****************************************
	// edge detection
	// ****************************************
	assign chgRise   = chargerState & ~s_r.chgPrev;
	assign gpioChg   = generalPin ^ s_r.gpioPrev;
	assign buckRise  = buckUndervoltage & ~s_r.buckUvPrev;
	assign ldoRise   = linearUndervoltage & ~s_r.ldoUvPrev;
	assign pbChg     = pushbuttonStatus ^ s_r.pbPrev;
	assign sclRise   = scl & ~s_r.sclPrev;
	assign sclFall   = ~scl & s_r.sclPrev;
	assign startCond = scl & s_r.sclPrev & s_r.sdaPrev & ~sdaIn;
	assign stopCond  = scl & s_r.sclPrev & ~s_r.sdaPrev & sdaIn;
	assign pending   = (|(s_r.ev1 & ~s_r.mask1)) | (|(s_r.ev2 & ~s_r.mask2));

	// ****************************************
	// register read mux
	// ****************************************
	function automatic logic [7:0] rdMux(
		input logic [7:0]  a,
		input pelr_state_s s
	);
		case (a)
			`PELR_ADR_VOLT:  rdMux = s.buckVolt;
			`PELR_ADR_MASK1: rdMux = s.mask1;
			`PELR_ADR_MASK2: rdMux = s.mask2;
			`PELR_ADR_EV1:   rdMux = s.ev1;
			`PELR_ADR_EV2:   rdMux = {s.ev2[7:1], 1'b0};
			default:         rdMux = 8'h00;
		endcase
	endfunction

	assign rdData = rdMux(s_r.ptr, s_r);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		doLoad = 1'b0;
		wrEn = 1'b0;
		trip = 1'b0;
		clr1 = 8'h00;
		clr2 = 8'h00;
		s_nxt.sclPrev = scl;
		s_nxt.sdaPrev = sdaIn;
		s_nxt.resetReq = 1'b0;
		if (startCond) begin
			s_nxt.st = PELR_ADDR;
			s_nxt.bitCnt = 4'h0;
			s_nxt.sdaOeN = 1'b1;
		end else if (stopCond) begin
			s_nxt.st = PELR_IDLE;
			s_nxt.sdaOeN = 1'b1;
		end else if (sclRise) begin
			case (s_r.st)
				PELR_ADDR, PELR_WREG, PELR_WDAT: begin
					s_nxt.shift = {s_r.shift[6:0], sdaIn};
					s_nxt.bitCnt = s_r.bitCnt + 4'h1;
				end
				PELR_MACK: s_nxt.nack = sdaIn;
				default: s_nxt.nack = s_r.nack;
			endcase
		end else if (sclFall) begin
			case (s_r.st)
				PELR_ADDR: begin
					if (s_r.bitCnt == 4'h8) begin
						s_nxt.bitCnt = 4'h0;
						if (s_r.shift[7:1] == `PELR_I2C_ADDR) begin
							s_nxt.rw = s_r.shift[0];
							s_nxt.sdaOeN = 1'b0;
							s_nxt.st = PELR_ACKA;
						end else begin
							s_nxt.st = PELR_IDLE;
						end
					end
				end
				PELR_ACKA: begin
					if (s_r.rw) begin
						doLoad = 1'b1;
					end else begin
						s_nxt.sdaOeN = 1'b1;
						s_nxt.bitCnt = 4'h0;
						s_nxt.st = PELR_WREG;
					end
				end
				PELR_WREG: begin
					if (s_r.bitCnt == 4'h8) begin
						s_nxt.ptr = s_r.shift;
						s_nxt.sdaOeN = 1'b0;
						s_nxt.st = PELR_ACKW;
					end
				end
				PELR_ACKW: begin
					s_nxt.sdaOeN = 1'b1;
					s_nxt.bitCnt = 4'h0;
					s_nxt.st = PELR_WDAT;
				end
				PELR_WDAT: begin
					if (s_r.bitCnt == 4'h8) begin
						wrEn = 1'b1;
						s_nxt.ptr = s_r.ptr + 8'h01;
						s_nxt.sdaOeN = 1'b0;
						s_nxt.st = PELR_ACKW;
					end
				end
				PELR_RDAT: begin
					if (s_r.bitCnt == 4'h8) begin
						s_nxt.sdaOeN = 1'b1;
						s_nxt.st = PELR_MACK;
					end else begin
						s_nxt.sdaOeN = s_r.shift[7];
						s_nxt.shift = {s_r.shift[6:0], 1'b0};
						s_nxt.bitCnt = s_r.bitCnt + 4'h1;
					end
				end
				PELR_MACK: begin
					if (!s_r.nack) begin
						doLoad = 1'b1;
					end else begin
						s_nxt.st = PELR_IDLE;
					end
				end
				default: s_nxt.st = PELR_IDLE;
			endcase
		end
		// the byte is latched for shifting here, so the flags clear as it goes out
		if (doLoad) begin
			s_nxt.shift = {rdData[6:0], 1'b0};
			s_nxt.sdaOeN = rdData[7];
			s_nxt.ptr = s_r.ptr + 8'h01;
			s_nxt.bitCnt = 4'h1;
			s_nxt.st = PELR_RDAT;
			if (s_r.ptr == `PELR_ADR_EV1) begin
				clr1 = 8'hFF;
			end
			if (s_r.ptr == `PELR_ADR_EV2) begin
				clr2 = 8'hFF;
			end
		end
		if (wrEn) begin
			case (s_r.ptr)
				`PELR_ADR_MASK1: s_nxt.mask1 = s_r.shift;
				`PELR_ADR_MASK2: s_nxt.mask2 = {s_r.shift[7:1], 1'b1};
				`PELR_ADR_VOLT: begin
					s_nxt.buckVolt = s_r.shift;
					// codes are linear from 0 V, so a ratio of codes is a ratio of volts
					trip = ({8'h00, s_r.shift} * `PELR_PCT_BASE) >
						({8'h00, s_r.buckVolt} * (`PELR_PCT_BASE + `PELR_STEP_PCT));
				end
				default: s_nxt.buckVolt = s_r.buckVolt;
			endcase
		end
		s_nxt.resetReq = trip;
		s_nxt.chgPrev = chargerState;
		s_nxt.gpioPrev = generalPin;
		s_nxt.buckUvPrev = buckUndervoltage;
		s_nxt.ldoUvPrev = linearUndervoltage;
		s_nxt.pbPrev = pushbuttonStatus;
		// set wins over a clear in the same cycle
		s_nxt.ev1 = (s_r.ev1 & ~clr1) | chgRise;
		s_nxt.ev2 = ({s_r.ev2[7:1], 1'b0} & ~clr2) |
			{gpioChg, buckRise | trip, ldoRise, pbChg, 1'b0};
		s_nxt.irq = pending;
		if (undervoltageLockout) begin
			s_nxt = RST_S;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_r <= RST_S;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sdaOut       = s_r.sdaOut;
	assign sdaOeN       = s_r.sdaOeN;
	assign buckVoltage  = s_r.buckVolt;
	assign resetRequest = s_r.resetReq;
	assign interrupt    = s_r.irq;

	// ****************************************
	// checks
	// ****************************************
	a_chg_rise_set: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && chgRise != 8'h00) |=>
		((s_r.ev1 & $past(chgRise)) == $past(chgRise)))
		else $error("charger event not latched");

	a_read_clear: assert property (@(posedge clock) disable iff (rst)
		(doLoad && s_r.ptr == `PELR_ADR_EV1 && chgRise == 8'h00) |=>
		(s_r.ev1 == 8'h00))
		else $error("charger flags not cleared by read");

	a_irq_follow: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && pending) |=> interrupt)
		else $error("unmasked flag without interrupt");

	a_mask_block: assert property (@(posedge clock) disable iff (rst)
		(!pending) |=> !interrupt)
		else $error("interrupt with all flags masked");

	a_pin_edge: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && gpioChg != 4'h0) |=>
		((s_r.ev2[7:4] & $past(gpioChg)) == $past(gpioChg)))
		else $error("pin change not latched");

	a_pg_rise: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && buckRise && ldoRise) |=> (s_r.ev2[3:2] == 2'b11))
		else $error("power-good event not latched");

	a_pb_edge: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && pbChg) |=> s_r.ev2[1])
		else $error("pushbutton event not latched");

	a_step_trip: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && wrEn && s_r.ptr == `PELR_ADR_VOLT &&
		// widened so a high present code cannot wrap the limit
		({8'h00, s_r.shift} * `PELR_PCT_BASE) >
		({8'h00, s_r.buckVolt} * (`PELR_PCT_BASE + `PELR_STEP_PCT))) |=>
		(resetRequest && s_r.ev2[3]))
		else $error("large step did not trip");

	a_step_down: assert property (@(posedge clock) disable iff (rst)
		(!undervoltageLockout && wrEn && s_r.ptr == `PELR_ADR_VOLT &&
		s_r.shift <= s_r.buckVolt) |=>
		(!resetRequest && buckVoltage == $past(s_r.shift)))
		else $error("lower setting not taken");

	a_lockout_load: assert property (@(posedge clock) disable iff (rst)
		undervoltageLockout |=> (s_r.mask1 == 8'hFF && s_r.mask2 == 8'hFF &&
		s_r.ev1 == 8'h00 && s_r.ev2 == 8'h00 && buckVoltage == `PELR_VOLT_RST))
		else $error("lockout defaults wrong");

	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		!s_r.ev2[0])
		else $error("reserved bit set");

endmodule

// ---- testbench/pelr_host_model.sv ----
// serial link host model
module pelr_host_model (
	input  wire logic clock,
	output logic      scl,
	output logic      sdaRel,
	input  wire logic sdaWire
);
	timeunit 1ns;
	timeprecision 100ps;
	// ***
	// bit level
	// ***
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end
	// four clocks a phase, twice the minimum
	task automatic half();
		repeat (4) @(posedge clock);
	endtask
	task automatic bitOut(input logic b);
		sdaRel <= b;
		half();
		scl <= 1'b1;
		half();
		scl <= 1'b0;
	endtask
	task automatic bitIn(output logic b);
		sdaRel <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		b = sdaWire;
		scl <= 1'b0;
	endtask
	task automatic start();
		sdaRel <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sdaRel <= 1'b0;
		half();
		scl <= 1'b0;
	endtask
	task automatic stop();
		sdaRel <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sdaRel <= 1'b1;
		half();
	endtask
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitOut(d[i]);
		bitIn(a);
		ack = ~a;
	endtask
	task automatic getByte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) bitIn(d[i]);
		bitOut(last);
	endtask
endmodule

// ---- testbench/pmic_event_latch_regs_tb.sv ----
// bench of the event-latch register block
`include "pelr_params.svh"
module pmic_event_latch_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clock, rst, lock, buv, luv, pb;
	logic [7:0] chg, r, m, d, old;
	logic [3:0] gp;
	logic       a;
	wire        scl, sdaRel, sdaW, sdaOut, sdaOeN, rstReq, irq;
	wire  [7:0] buck;
	int         err_total, checks, pulses, expP;
	logic [7:0] steps [7] = '{8'h20, 8'h22, 8'h24, 8'h40, 8'h19, 8'h1B, 8'h10};
	// released sda floats high by pull-up
	assign sdaW = sdaRel & (sdaOeN | sdaOut);
	pmic_event_latch_regs u_dut (
		.clock(clock), .rst(rst), .undervoltageLockout(lock), .scl(scl),
		.sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .chargerState(chg),
		.generalPin(gp), .buckUndervoltage(buv), .linearUndervoltage(luv),
		.pushbuttonStatus(pb), .buckVoltage(buck), .resetRequest(rstReq),
		.interrupt(irq)
	);
	pelr_host_model u_host (.clock(clock), .scl(scl), .sdaRel(sdaRel), .sdaWire(sdaW));
	// ***
	// helpers
	// ***
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (rstReq === 1'b1) pulses++;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d of %0d checks", err_total, checks);
		if (err_total == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic setPtr(input logic [7:0] p);
		u_host.start();
		u_host.sendByte({`PELR_I2C_ADDR, 1'b0}, a);
		check({7'h00, a}, 8'h01);
		u_host.sendByte(p, a);
		check({7'h00, a}, 8'h01);
	endtask
	task automatic wrReg(input logic [7:0] p, input logic [7:0] v);
		setPtr(p);
		u_host.sendByte(v, a);
		u_host.stop();
	endtask
	task automatic rdReg(input logic [7:0] p, output logic [7:0] v);
		setPtr(p);
		u_host.start();
		u_host.sendByte({`PELR_I2C_ADDR, 1'b1}, a);
		u_host.getByte(1'b1, v);
		u_host.stop();
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// upward step beyond the limit trips the comparator
	function automatic int tooBig(input logic [7:0] o, input logic [7:0] n);
		return int'(n) * `PELR_PCT_BASE > int'(o) * (`PELR_PCT_BASE + `PELR_STEP_PCT);
	endfunction
	initial begin
		repeat (90000) @(posedge clock);
		err_total++;
		summarize();
	end
	// ***
	// sequence
	// ***
	initial begin
		{rst, lock, chg, gp, buv, luv, pb} = {1'b1, 16'h0000};
		void'($urandom(32226));
		wt(12);
		rst <= 1'b0;
		wt(2);
		check(buck, `PELR_VOLT_RST);
		check({7'h00, irq}, 8'h00);
		rdReg(`PELR_ADR_MASK1, d);
		check(d, 8'hFF);
		rdReg(`PELR_ADR_EV1, d);
		check(d, 8'h00);
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 8'hFF : 8'($urandom);
			m = (i == 0) ? 8'h00 : 8'($urandom);
			wrReg(`PELR_ADR_MASK1, m);
			chg <= r;
			wt(3);
			check({7'h00, irq}, {7'h00, |(r & ~m)});
			chg <= 8'h00;
			wt(3);
			rdReg(`PELR_ADR_EV1, d);
			check(d, r);
			rdReg(`PELR_ADR_EV1, d);
			check(d, 8'h00);
			check({7'h00, irq}, 8'h00);
		end
		m = 8'($urandom);
		gp <= 4'($urandom) | 4'h1;
		wrReg(`PELR_ADR_MASK2, m);
		{buv, luv, pb} <= 3'b111;
		wt(3);
		check({7'h00, irq}, {7'h00, |({gp, 4'hE} & ~m)});
		rdReg(`PELR_ADR_EV2, d);
		check(d, {gp, 4'hE});
		r = {gp, 4'h2};
		{gp, buv, luv, pb} <= 7'h00;
		wt(3);
		rdReg(`PELR_ADR_EV2, d);
		check(d, r);
		rdReg(`PELR_ADR_EV2, d);
		check(d, 8'h00);
		rdReg(`PELR_ADR_MASK2, d);
		check(d, m | 8'h01);
		old = `PELR_VOLT_RST;
		// down, two under the limit, one over, down, one exactly at the limit, down
		foreach (steps[i]) begin
			wrReg(`PELR_ADR_VOLT, steps[i]);
			expP += tooBig(old, steps[i]);
			old = steps[i];
			check(buck, old);
		end
		check(8'(pulses), 8'(expP));
		rdReg(`PELR_ADR_EV2, d);
		check(d, 8'h08);
		wrReg(8'h30, 8'h5A);
		rdReg(8'h30, d);
		check(d, 8'h00);
		u_host.start();
		u_host.sendByte(8'hA0, a);
		u_host.stop();
		check({7'h00, a}, 8'h00);
		wrReg(`PELR_ADR_MASK1, 8'h00);
		chg <= 8'h81;
		wt(3);
		lock <= 1'b1;
		chg <= 8'h00;
		wt(2);
		lock <= 1'b0;
		wt(2);
		check({irq, buck[6:0]}, 8'h4A);
		rdReg(`PELR_ADR_MASK1, d);
		check(d, 8'hFF);
		rdReg(`PELR_ADR_EV1, d);
		check(d, 8'h00);
		summarize();
	end
endmodule
